//--- mac_sink_model.sv
/*
  Model of the MAC logic that takes the 64-bit output stream.
  Assumes no back-pressure: every valid beat is taken at once.
*/
`timescale 1ns/10ps
`default_nettype none
module mac_sink_model (
  input wire logic clk,
  input wire logic out_valid,
  input wire macsec_backend_pkg::beat_t out_beat,
  input wire logic out_abort,
  input wire logic [31:0] out_fcs_code,
  output logic [15:0] beats,
  output logic [7:0] frames,
  output logic [63:0] sop_data,
  output logic abort_seen,
  output logic [31:0] fcs_seen
);
  import macsec_backend_pkg::*;
  initial begin
    beats = 16'h0000;
    frames = 8'h00;
  end
  // Takes one beat per valid cycle, notes frame ends and verdicts
  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      beats <= beats + 16'h0001;
      if (out_beat.sop) sop_data <= out_beat.data;
      if (out_beat.eop) begin
        frames <= frames + 8'h01;
        abort_seen <= out_abort;
        fcs_seen <= out_fcs_code;
      end
    end
  end
endmodule
`default_nettype wire

//--- macsec_backend.sv
/*
  Back half of a streaming MACsec pipeline: width converters, transform stage,
  consistency checker, post-processing, statistics and latency control.
  Assumes an external AES core supplies keystream and ICV aligned to each word,
  and that the ICV occupies a whole final 128-bit word on ingress.
*/
// What this block does
// - Measure first-word latency of every frame
// - Hold output until latency reaches target
// - Select GCM-AES-128 or GCM-AES-256 suite
// - Also support XPN suites, both key sizes
// - Edit, encrypt, authenticate, append or verify ICV
// - Confidentiality offset zero to 127 bytes
// - Bypassed VLAN tags left unencrypted, unauthenticated except in MPLS frames
// - MPLS link header left uncovered
// - Ingress frames checked against programmable rules
// - Highest priority matching rule wins
// - Egress build has no consistency checker
// - Compliance check failure drops frame
// - MTU check, global or per user priority
// - Merge all verdicts into one drop
// - Choose counters from crypto and checker results
// - Counter RMW yields to external reads
// - Selected counters can be suppressed
// - Convert 128-bit stream to 64-bit stream
// - Debug code in FCS of failed frames
// - Classification fields selectable per association
// - MPLS labels and SecTAG usable for classification
// - Rejection by abort on last word
// - Convert 64-bit input to 128-bit with port
`timescale 1ns/10ps
`default_nettype none
`include "macsec_backend_regs.svh"
module macsec_backend #(
  parameter bit INGRESS = 1'b1,
  parameter int CC_RULES = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic in_valid,
  input wire macsec_backend_pkg::beat_t in_beat,
  input wire macsec_backend_pkg::tok_t in_tok,
  input wire logic [1:0] in_port,
  output logic in_ready,
  input wire logic [127:0] ks_data,
  input wire logic [127:0] icv_in,
  output macsec_backend_pkg::suite_t cipher_suite,
  output logic [8:0] cls_sel_out,
  output logic auth_valid,
  output logic [127:0] auth_data,
  output logic [15:0] auth_mask,
  output logic out_valid,
  output macsec_backend_pkg::beat_t out_beat,
  output logic [1:0] out_port,
  output logic out_abort,
  output logic [31:0] out_fcs_code
);
  import macsec_backend_pkg::*;

  // Byte lane mask: bit 15-i set when byte off+i lies in [lo,hi)
  function automatic logic [15:0] rng(input logic [11:0] off, input logic [11:0] lo,
                                      input logic [11:0] hi);
    logic [11:0] p;
    rng = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      p = off + 12'(i);
      rng[15-i] = (p >= lo) && (p < hi);
    end
  endfunction

  function automatic beat_t mk_beat(input logic [63:0] d, input logic s, input logic e,
                                    input logic er, input logic [3:0] n);
    mk_beat = '{data: d, sop: s, eop: e, err: er, nbytes: n};
  endfunction

  logic lat_en_reg;
  logic [15:0] lat_tgt_reg, mtu_glb_reg, last_lat_reg, now_reg;
  logic [5:0] skip_reg, st_pend_reg;
  logic [15:0] mtu_prio_reg [0:7];
  logic [21:0] cc_rule_reg [0:CC_RULES-1];
  logic [8:0] cls_sel_reg [0:15];
  logic [31:0] st_ram [0:7];
  logic [15:0] ent_reg [0:3];
  logic [1:0] ent_wr_reg, ent_rd_reg;
  beat_t half_reg;
  logic half_v_reg, s1_v_reg, s2_v_reg;
  tok_t tok_hold_reg;
  word_t s1_reg, s2_reg;
  logic [11:0] off_reg;
  logic [15:0] len_reg;
  logic [127:0] s2_icv_reg, oc_buf_reg;
  logic fr_tag_reg, fr_icvbad_reg, fr_cc_hit_reg, fr_cc_drop_reg;
  logic [2:0] fr_pcp_reg;
  oc_state_t oc_state_reg;
  logic oc_fin_reg, oc_app_reg, oc_drop_reg, oc_err_reg;
  logic [31:0] oc_code_reg;
  logic [3:0] oc_hinb_reg;
  word_t w_in;
  logic acc, form, s2_take, s2_free, s1_adv, gate_ok, st_rd;
  logic [15:0] lat_now, lat_meas, cmask, amask, fin_len, mtu_sel;
  logic [11:0] cur_off, base, a_lo, a_hi, c_start;
  logic [127:0] xd, kmask;
  logic cc_hit, cc_drop, cc_better, mtu_bad, comp_fail, drop;
  logic [3:0] cc_prio;
  logic [5:0] st_new;
  logic [2:0] st_idx;

  // Register writes: configuration that steers the pipeline
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lat_en_reg <= 1'b0;
      lat_tgt_reg <= `LAT_TGT_RST;
      mtu_glb_reg <= `MTU_RST;
      skip_reg <= 6'h00;
      for (int i = 0; i < 8; i++) mtu_prio_reg[i] <= `MTU_RST;
      for (int i = 0; i < CC_RULES; i++) cc_rule_reg[i] <= 22'h000000;
      for (int i = 0; i < 16; i++) cls_sel_reg[i] <= 9'h000;
    end else if (ce && wr) begin
      if (addr == `A_CTRL) lat_en_reg <= wdata[`CTRL_LAT_EN];
      if (addr == `A_LAT_TGT) lat_tgt_reg <= wdata[15:0];
      if (addr == `A_MTU_GLB) mtu_glb_reg <= wdata[15:0];
      if (addr == `A_SKIP) skip_reg <= wdata[5:0];
      if (addr[7:5] == 3'h1 && addr[1:0] == 2'h0) mtu_prio_reg[addr[4:2]] <= wdata[15:0];
      if (addr[7:6] == 2'h1 && addr[1:0] == 2'h0 && 32'(addr[5:2]) < CC_RULES)
        cc_rule_reg[addr[5:2]] <= wdata[21:0];
      if (addr[7:6] == 2'h2 && addr[1:0] == 2'h0) cls_sel_reg[addr[5:2]] <= wdata[8:0];
    end
  end

  // Register reads, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= 32'h0000_0000;
      if (rd) begin
        if (addr == `A_CTRL) rdata <= {31'h0, lat_en_reg};
        if (addr == `A_LAT_TGT) rdata <= {16'h0000, lat_tgt_reg};
        if (addr == `A_MTU_GLB) rdata <= {16'h0000, mtu_glb_reg};
        if (addr == `A_SKIP) rdata <= {26'h0, skip_reg};
        if (addr == `A_LAST_LAT) rdata <= {16'h0000, last_lat_reg};
        if (addr[7:5] == 3'h1 && addr[1:0] == 2'h0) rdata <= {16'h0000, mtu_prio_reg[addr[4:2]]};
        if (addr[7:6] == 2'h1 && addr[1:0] == 2'h0 && 32'(addr[5:2]) < CC_RULES)
          rdata <= {10'h000, cc_rule_reg[addr[5:2]]};
        if (addr[7:6] == 2'h2 && addr[1:0] == 2'h0) rdata <= {23'h0, cls_sel_reg[addr[5:2]]};
        if (addr[7:5] == 3'h6 && addr[1:0] == 2'h0) rdata <= st_ram[addr[4:2]];
      end
    end
  end

  // Handshake and stall terms
  always_comb begin
    lat_now = now_reg - ent_reg[ent_rd_reg];
    lat_meas = lat_now + 16'h0001; // Latency a take at this edge records
    gate_ok = !s2_reg.sop || !lat_en_reg || (lat_meas >= lat_tgt_reg);
    s2_take = (oc_state_reg == OC_IDLE) && s2_v_reg && gate_ok &&
              !(s2_reg.eop && st_pend_reg != 6'h00);
    s2_free = !s2_v_reg || s2_take;
    s1_adv = s1_v_reg && s2_free;
    acc = in_valid && in_ready;
    form = acc && (half_v_reg || in_beat.eop);
  end

  // Input width converter: pairs 64-bit beats into one 128-bit word
  always_comb begin
    w_in.data = half_v_reg ? {half_reg.data, in_beat.data} : {in_beat.data, 64'h0};
    w_in.sop = half_v_reg ? half_reg.sop : in_beat.sop;
    w_in.eop = in_beat.eop;
    w_in.err = in_beat.err || (half_v_reg && half_reg.err);
    w_in.nbytes = half_v_reg ? 5'(in_beat.nbytes) + 5'h08 : 5'(in_beat.nbytes);
    w_in.port = in_port;
    w_in.tok = w_in.sop && !half_v_reg ? in_tok : tok_hold_reg;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_v_reg <= 1'b0;
      half_reg <= '0;
      tok_hold_reg <= '0;
      s1_v_reg <= 1'b0;
      s1_reg <= '0;
      in_ready <= 1'b0;
    end else if (ce) begin
      if (acc && in_beat.sop) tok_hold_reg <= in_tok;
      if (acc && !form) half_reg <= in_beat;
      if (acc) half_v_reg <= !form;
      if (form) s1_reg <= w_in;
      s1_v_reg <= form || (s1_v_reg && !s1_adv);
      in_ready <= !(form || (s1_v_reg && !s1_adv));
    end
  end

  // Entry timestamps of first words and free-running cycle count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      now_reg <= 16'h0000;
      ent_wr_reg <= 2'h0;
      ent_rd_reg <= 2'h0;
      last_lat_reg <= 16'h0000;
      for (int i = 0; i < 4; i++) ent_reg[i] <= 16'h0000;
    end else if (ce) begin
      now_reg <= now_reg + 16'h0001;
      if (form && w_in.sop) begin
        ent_reg[ent_wr_reg] <= now_reg;
        ent_wr_reg <= ent_wr_reg + 2'h1;
      end
      if (s2_take && s2_reg.sop) begin
        last_lat_reg <= lat_meas;
        ent_rd_reg <= ent_rd_reg + 2'h1;
      end
    end
  end

  // Transform stage byte windows
  always_comb begin
    cur_off = s1_reg.sop ? 12'h000 : off_reg;
    base = s1_reg.tok.mpls ? (s1_reg.tok.two_labels ? 12'h016 : 12'h012) : 12'h000;
    a_lo = s1_reg.tok.mpls ? 12'h000 : `HDR_LEN;
    a_hi = s1_reg.tok.mpls ? base : `HDR_LEN + {8'h00, s1_reg.tok.vlan_byp, 2'b00};
    c_start = base + `HDR_LEN + {8'h00, s1_reg.tok.vlan_byp, 2'b00} + `SECTAG_LEN +
              {5'h00, s1_reg.tok.co};
    cmask = (s1_reg.tok.prot && s1_reg.tok.conf && !(INGRESS && s1_reg.eop)) ?
            rng(cur_off, c_start, 12'hFFF) : 16'h0000;
    amask = s1_reg.tok.prot ? ~rng(cur_off, a_lo, a_hi) : 16'h0000;
    for (int i = 0; i < 16; i++) kmask[8*i +: 8] = {8{cmask[i]}};
    xd = s1_reg.data ^ (ks_data & kmask);
  end

  // Consistency checker over the word leaving the transform
  always_comb begin
    cc_hit = 1'b0;
    cc_drop = 1'b0;
    cc_prio = 4'h0;
    cc_better = 1'b0;
    for (int i = 0; i < CC_RULES; i++) begin
      if (INGRESS && cc_rule_reg[i][`CC_EN_BIT] && cc_rule_reg[i][15:0] == xd[31:16] &&
          (!cc_hit || cc_rule_reg[i][`CC_PRIO_LSB +: 4] > cc_prio)) begin
        cc_hit = 1'b1;
        cc_prio = cc_rule_reg[i][`CC_PRIO_LSB +: 4];
        cc_drop = cc_rule_reg[i][`CC_DROP_BIT];
      end
    end
    for (int i = 0; i < CC_RULES; i++)
      if (cc_hit && cc_rule_reg[i][`CC_EN_BIT] && cc_rule_reg[i][15:0] == xd[31:16] &&
          cc_rule_reg[i][`CC_PRIO_LSB +: 4] > cc_prio) cc_better = 1'b1;
  end

  // Transform stage and per-frame results
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s2_v_reg <= 1'b0;
      s2_reg <= '0;
      s2_icv_reg <= '0;
      off_reg <= 12'h000;
      len_reg <= 16'h0000;
      {fr_tag_reg, fr_icvbad_reg, fr_cc_hit_reg, fr_cc_drop_reg} <= 4'h0;
      fr_pcp_reg <= 3'h0;
      {auth_valid, auth_data, auth_mask} <= '0;
      cipher_suite <= SUITE_GCM_128;
      cls_sel_out <= 9'h000;
    end else if (ce) begin
      auth_valid <= s1_adv && s1_reg.tok.prot;
      if (form && w_in.sop) begin
        cipher_suite <= w_in.tok.suite;
        cls_sel_out <= cls_sel_reg[w_in.tok.sa] |
                       (INGRESS ? 9'h100 : 9'h000);
      end
      if (s1_adv) begin
        s2_reg <= s1_reg;
        s2_reg.data <= xd;
        auth_data <= xd;
        auth_mask <= amask;
        off_reg <= (cur_off > 12'hF00) ? cur_off : cur_off + 12'h010;
        len_reg <= (s1_reg.sop ? 16'h0000 : len_reg) + 16'(s1_reg.nbytes);
        if (s1_reg.eop) s2_icv_reg <= icv_in;
        if (s1_reg.sop) begin
          fr_tag_reg <= xd[31:16] == `TPID_VLAN;
          fr_pcp_reg <= xd[15:13];
          fr_cc_hit_reg <= cc_hit;
          fr_cc_drop_reg <= cc_drop;
        end
        fr_icvbad_reg <= (s1_reg.sop ? 1'b0 : fr_icvbad_reg) ||
                         (INGRESS && s1_reg.eop && s1_reg.tok.prot && s1_reg.data != icv_in);
      end
      s2_v_reg <= s1_adv || (s2_v_reg && !s2_take);
    end
  end

  // Post-processing verdicts at the end of each frame
  always_comb begin
    fin_len = len_reg + ((!INGRESS && s2_reg.tok.prot) ? `ICV_LEN : 16'h0000);
    mtu_sel = fr_tag_reg ? mtu_prio_reg[fr_pcp_reg] : mtu_glb_reg;
    mtu_bad = fin_len > mtu_sel;
    comp_fail = fr_icvbad_reg || (s2_reg.tok.prot && !s2_reg.tok.conf && s2_reg.tok.co != 7'h00);
    drop = s2_reg.tok.cls_drop || comp_fail || mtu_bad || fr_cc_drop_reg;
    st_new = 6'h00;
    st_new[drop ? `ST_DROP : `ST_PASS] = 1'b1;
    st_new[`ST_ICV] = fr_icvbad_reg;
    st_new[`ST_MTU] = mtu_bad;
    st_new[`ST_CCDROP] = fr_cc_drop_reg;
    st_new[`ST_CCPASS] = fr_cc_hit_reg && !fr_cc_drop_reg;
    st_rd = rd && addr[7:5] == 3'h6;
    st_idx = 3'h0;
    for (int i = 5; i >= 0; i--) if (st_pend_reg[i]) st_idx = 3'(i);
  end

  // Statistics updater: external reads take the RAM first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_pend_reg <= 6'h00;
      for (int i = 0; i < 8; i++) st_ram[i] <= 32'h0000_0000;
    end else if (ce) begin
      if (st_pend_reg != 6'h00 && !st_rd) begin
        st_ram[st_idx] <= st_ram[st_idx] + 32'h0000_0001;
        st_pend_reg <= (st_pend_reg & ~(6'h01 << st_idx)) |
                       ((s2_take && s2_reg.eop && !s2_reg.err) ? st_new & ~skip_reg : 6'h00);
      end else if (s2_take && s2_reg.eop && !s2_reg.err) begin
        st_pend_reg <= st_pend_reg | (st_new & ~skip_reg);
      end
    end
  end

  // Output width converter: two 64-bit beats per word, one for a final word of 8 bytes or fewer, ICV word appended on egress protected frames
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oc_state_reg <= OC_IDLE;
      {oc_buf_reg, oc_fin_reg, oc_app_reg, oc_drop_reg, oc_err_reg} <= '0;
      oc_code_reg <= 32'h0000_0000;
      oc_hinb_reg <= 4'h0;
      {out_valid, out_beat, out_abort, out_fcs_code} <= '0;
      out_port <= 2'h0;
    end else if (ce) begin
      {out_valid, out_abort} <= 2'b00;
      out_fcs_code <= 32'h0000_0000;
      unique case (oc_state_reg)
        OC_IDLE: begin
          if (s2_take) begin
            oc_buf_reg <= s2_reg.data;
            oc_err_reg <= s2_reg.err;
            oc_app_reg <= s2_reg.eop && !INGRESS && s2_reg.tok.prot;
            oc_fin_reg <= s2_reg.eop && !(!INGRESS && s2_reg.tok.prot);
            oc_drop_reg <= s2_reg.eop && drop;
            oc_code_reg <= comp_fail ? (fr_icvbad_reg ? `FCS_ICV_FAIL : `FCS_COMP_FAIL)
                           : 32'h0000_0000;
            oc_hinb_reg <= s2_reg.eop ? 4'(s2_reg.nbytes - 5'h08) : 4'h8;
            out_valid <= 1'b1;
            out_port <= s2_reg.port;
            if (s2_reg.eop && s2_reg.nbytes <= 5'h08 && !(!INGRESS && s2_reg.tok.prot)) begin
              out_beat <= mk_beat(s2_reg.data[127:64], s2_reg.sop, 1'b1, s2_reg.err,
                                  4'(s2_reg.nbytes));
              out_abort <= drop;
              out_fcs_code <= drop && comp_fail ?
                              (fr_icvbad_reg ? `FCS_ICV_FAIL : `FCS_COMP_FAIL) : 32'h0000_0000;
            end else begin
              out_beat <= mk_beat(s2_reg.data[127:64], s2_reg.sop, 1'b0, s2_reg.err,
                                  s2_reg.eop && s2_reg.nbytes < 5'h08 ? 4'(s2_reg.nbytes) : 4'h8);
              if (s2_reg.eop && s2_reg.nbytes <= 5'h08) begin
                oc_buf_reg <= s2_icv_reg;
                oc_state_reg <= OC_ICV_LO;
              end else begin
                oc_state_reg <= OC_HI;
              end
            end
          end
        end
        OC_HI: begin
          out_valid <= 1'b1;
          out_beat <= mk_beat(oc_buf_reg[63:0], 1'b0, oc_fin_reg, oc_err_reg, oc_hinb_reg);
          out_abort <= oc_fin_reg && oc_drop_reg;
          out_fcs_code <= oc_fin_reg && oc_drop_reg ? oc_code_reg : 32'h0000_0000;
          oc_buf_reg <= s2_icv_reg;
          oc_state_reg <= oc_app_reg ? OC_ICV_LO : OC_IDLE;
        end
        OC_ICV_LO: begin
          out_valid <= 1'b1;
          out_beat <= mk_beat(oc_buf_reg[127:64], 1'b0, 1'b0, oc_err_reg, 4'h8);
          oc_state_reg <= OC_ICV_HI;
        end
        OC_ICV_HI: begin
          out_valid <= 1'b1;
          out_beat <= mk_beat(oc_buf_reg[63:0], 1'b0, 1'b1, oc_err_reg, 4'h8);
          out_abort <= oc_drop_reg;
          out_fcs_code <= oc_drop_reg ? oc_code_reg : 32'h0000_0000;
          oc_state_reg <= OC_IDLE;
        end
      endcase
    end
  end

  // Checks on the pipeline's own behaviour
  sequence s_load_mid;
    s2_take && !s2_reg.eop;
  endsequence
  sequence s_two_beats;
    out_valid && !out_beat.eop ##1 out_valid;
  endsequence
  property p_lat_hold;
    @(posedge clk) disable iff (!nrst) ce && s2_take && s2_reg.sop && lat_en_reg
      |-> lat_meas >= lat_tgt_reg;
  endproperty
  a_lat_hold: assert property (p_lat_hold) else $error("frame left before latency target");
  property p_lat_free;
    @(posedge clk) disable iff (!nrst) ce && !lat_en_reg && s2_v_reg && oc_state_reg == OC_IDLE
      && !(s2_reg.eop && st_pend_reg != 6'h00) |-> s2_take;
  endproperty
  a_lat_free: assert property (p_lat_free) else $error("stall without latency control");
  property p_lat_meas;
    @(posedge clk) disable iff (!nrst) ce && s2_take && s2_reg.sop
      |=> ce |-> last_lat_reg == $past(lat_now) + 16'h0001;
  endproperty
  a_lat_meas: assert property (p_lat_meas) else $error("latency not recorded");
  property p_abort_last;
    @(posedge clk) disable iff (!nrst) out_abort |-> out_valid && out_beat.eop;
  endproperty
  a_abort_last: assert property (p_abort_last) else $error("abort off last beat");
  property p_fcs_code;
    @(posedge clk) disable iff (!nrst) out_fcs_code != 32'h0000_0000 |-> out_abort;
  endproperty
  a_fcs_code: assert property (p_fcs_code) else $error("debug code on passing frame");
  property p_cc_prio;
    @(posedge clk) disable iff (!nrst) !cc_better && (INGRESS || !cc_hit);
  endproperty
  a_cc_prio: assert property (p_cc_prio) else $error("lower priority rule applied");
  property p_mtu_drop;
    @(posedge clk) disable iff (!nrst) ce && s2_take && s2_reg.eop && mtu_bad
      |=> oc_drop_reg || out_abort;
  endproperty
  a_mtu_drop: assert property (p_mtu_drop) else $error("oversize frame not dropped");
  property p_st_yield;
    @(posedge clk) disable iff (!nrst) ce && st_rd && st_pend_reg != 6'h00
      |=> st_pend_reg != 6'h00;
  endproperty
  a_st_yield: assert property (p_st_yield) else $error("counter update beat a read");
  property p_width;
    @(posedge clk) disable iff (!nrst || !ce) s_load_mid |=> s_two_beats;
  endproperty
  a_width: assert property (p_width) else $error("word not split into two beats");
  property p_in_pair;
    @(posedge clk) disable iff (!nrst) ce && acc && half_v_reg |=> s1_v_reg;
  endproperty
  a_in_pair: assert property (p_in_pair) else $error("beat pair not formed");
endmodule
`default_nettype wire

//--- macsec_backend_pkg.sv
/*
  Types of the MACsec pipeline back half: stream beats, words, token, states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package macsec_backend_pkg;
  typedef enum logic [1:0] {
    SUITE_GCM_128 = 2'h0, SUITE_GCM_256 = 2'h1, SUITE_XPN_128 = 2'h2, SUITE_XPN_256 = 2'h3
  } suite_t;
  // Processing token from the classification stages, one per frame
  typedef struct packed {
    logic prot;
    logic conf;
    suite_t suite;
    logic [6:0] co;
    logic [1:0] vlan_byp;
    logic mpls;
    logic two_labels;
    logic cls_drop;
    logic [3:0] sa;
  } tok_t;
  typedef struct packed {
    logic [63:0] data;
    logic sop;
    logic eop;
    logic err;
    logic [3:0] nbytes;
  } beat_t;
  typedef struct packed {
    logic [127:0] data;
    logic sop;
    logic eop;
    logic err;
    logic [4:0] nbytes;
    logic [1:0] port;
    tok_t tok;
  } word_t;
  typedef enum logic [3:0] {
    OC_IDLE = 4'h1, OC_HI = 4'h2, OC_ICV_LO = 4'h4, OC_ICV_HI = 4'h8
  } oc_state_t;
endpackage
`default_nettype wire

//--- macsec_backend_regs.svh
/*
  Register offsets, field positions, reset values and fixed constants of the
  MACsec pipeline back half. Assumes byte addresses on an 8-bit register port.
*/
`ifndef MACSEC_BACKEND_REGS_SVH
`define MACSEC_BACKEND_REGS_SVH
// Register offsets
`define A_CTRL 8'h00
`define A_LAT_TGT 8'h04
`define A_MTU_GLB 8'h08
`define A_SKIP 8'h0C
`define A_LAST_LAT 8'h10
`define A_MTU_PRIO 8'h20
`define A_CC_RULE 8'h40
`define A_CLS_SEL 8'h80
`define A_STATS 8'hC0
// Field positions
`define CTRL_LAT_EN 0
`define CC_PRIO_LSB 16
`define CC_DROP_BIT 20
`define CC_EN_BIT 21
`define CLS_LABEL2 7
`define CLS_SECTAG 8
// Reset values
`define LAT_TGT_RST 16'h0020
`define MTU_RST 16'h05EE
// Frame geometry in bytes
`define HDR_LEN 12'h00C
`define SECTAG_LEN 12'h010
`define ICV_LEN 16'h0010
`define TPID_VLAN 16'h8100
// Debug codes written into the FCS field of failed frames
`define FCS_ICV_FAIL 32'h5EC0_0001
`define FCS_COMP_FAIL 32'h5EC0_0002
// Statistics counter indices
`define ST_PASS 0
`define ST_DROP 1
`define ST_ICV 2
`define ST_MTU 3
`define ST_CCDROP 4
`define ST_CCPASS 5
`endif

//--- macsec_frame_pipeline_backend_tb_top.sv
/*
  Self-checking bench: register port tasks, frame driver and verdict checks.
  Assumes the ingress build, a zero keystream and a fixed frame ICV.
*/
`timescale 1ns/10ps
`default_nettype none
`include "macsec_backend_regs.svh"
module macsec_frame_pipeline_backend_tb_top;
  import macsec_backend_pkg::*;
  localparam logic [127:0] ICV = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, in_valid = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v, fcs, n_fail = 32'h0, checked = 32'h0;
  beat_t in_beat = '0, out_beat;
  tok_t in_tok = '0;
  suite_t cipher_suite;
  logic [8:0] cls_sel_out;
  logic [127:0] icv = ICV;
  logic in_ready, out_valid, out_abort, ab, auth_v;
  logic [7:0] n_auth = 8'h00;
  logic [1:0] out_port;
  logic [15:0] beats, b0;
  logic [7:0] frames;
  logic [63:0] sop_data;
  logic [31:0] out_fcs_code;
  always #50 clk = ~clk;
  // Counts protected words handed to the authenticator
  always @(posedge clk) if (auth_v === 1'b1) n_auth <= n_auth + 8'h01;
  macsec_backend dut (.clk(clk), .nrst(nrst), .ce(1'b1), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .in_valid(in_valid), .in_beat(in_beat),
    .in_tok(in_tok), .in_port(2'h1), .in_ready(in_ready), .ks_data(128'h0),
    .icv_in(icv), .cipher_suite(cipher_suite), .cls_sel_out(cls_sel_out),
    .auth_valid(auth_v), .auth_data(), .auth_mask(), .out_valid(out_valid),
    .out_beat(out_beat), .out_port(out_port), .out_abort(out_abort),
    .out_fcs_code(out_fcs_code));
  mac_sink_model sink (.clk(clk), .out_valid(out_valid), .out_beat(out_beat),
    .out_abort(out_abort), .out_fcs_code(out_fcs_code), .beats(beats), .frames(frames),
    .sop_data(sop_data), .abort_seen(ab), .fcs_seen(fcs));
  task conclude;
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked = checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // Sends a frame of nw words and waits for its last output beat
  task frame(input int nw, input logic p, input logic c, input suite_t s,
             input logic [6:0] co, input logic [127:0] lw);
    beat_t b; tok_t t; int k; logic [7:0] f0;
    t = '0; t.prot = p; t.conf = c; t.suite = s; t.co = co; t.sa = 4'h3;
    f0 = frames; b0 = beats;
    @(posedge clk);
    for (int i = 0; i < 2 * nw; i++) begin
      b.data = (i < 2 * nw - 2) ? {32'hA5A5_0000, 32'(i)} : (i[0] ? lw[63:0] : lw[127:64]);
      b.sop = (i == 0); b.eop = (i == 2 * nw - 1); b.err = 1'b0; b.nbytes = 4'h8;
      in_valid <= 1'b1; in_beat <= b; in_tok <= t;
      do begin
        @(negedge clk);
        k = (in_ready === 1'b1);
        @(posedge clk);
      end while (k == 0);
    end
    in_valid <= 1'b0;
    k = 0;
    while (frames == f0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    cmp({24'h0, frames}, f0 + 8'h01);
    cmp({30'h0, cipher_suite}, {30'h0, s});
  endtask
  initial begin
    #2000000;
    n_fail = n_fail + 1;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rreg(`A_LAT_TGT); cmp(v, 32'h20);
    rreg(`A_MTU_GLB); cmp(v, 32'h5EE);
    rreg(8'h18); cmp(v, 32'h0);
    wreg(`A_CLS_SEL + 8'h0C, 32'h7F);
    frame(2, 1'b0, 1'b0, SUITE_GCM_128, 7'h00, 128'h0);
    cmp(sop_data[31:0], 32'h0); cmp(sop_data[63:32], 32'hA5A5_0000);
    cmp({16'h0, beats - b0}, 32'h4); cmp({31'h0, ab}, 32'h0);
    cmp({23'h0, cls_sel_out}, 32'h17F);
    cmp({30'h0, out_port}, 32'h1);
    rreg(`A_LAST_LAT); cmp(v, 32'h3);
    wreg(`A_CTRL, 32'h1);
    frame(2, 1'b0, 1'b0, SUITE_GCM_256, 7'h00, 128'h0);
    rreg(`A_LAST_LAT); cmp(v, 32'h20);
    wreg(`A_CTRL, 32'h0); wreg(`A_MTU_GLB, 32'h10);
    frame(3, 1'b0, 1'b0, SUITE_XPN_128, 7'h00, 128'h0);
    cmp({31'h0, ab}, 32'h1); cmp(fcs, 32'h0);
    wreg(`A_MTU_GLB, 32'h5EE);
    frame(2, 1'b1, 1'b0, SUITE_XPN_256, 7'h05, ICV);
    cmp({31'h0, ab}, 32'h1); cmp(fcs, `FCS_COMP_FAIL);
    frame(2, 1'b1, 1'b1, SUITE_GCM_128, 7'h00, ~ICV);
    cmp({31'h0, ab}, 32'h1); cmp(fcs, `FCS_ICV_FAIL);
    cmp({24'h0, n_auth}, 32'h4);
    rreg(`A_STATS + 8'(4 * `ST_PASS)); cmp(v, 32'h2);
    rreg(`A_STATS + 8'(4 * `ST_MTU)); cmp(v, 32'h1);
    rreg(`A_STATS + 8'(4 * `ST_ICV)); cmp(v, 32'h1);
    wreg(`A_SKIP, 32'h1);
    frame(2, 1'b0, 1'b0, SUITE_GCM_128, 7'h00, 128'h0);
    rreg(`A_STATS + 8'(4 * `ST_PASS)); cmp(v, 32'h2);
    wreg(`A_CC_RULE, 32'h0031_0000);
    wreg(`A_CC_RULE + 8'h04, 32'h0022_0000);
    frame(2, 1'b0, 1'b0, SUITE_GCM_128, 7'h00, 128'h0);
    cmp({31'h0, ab}, 32'h0);
    rreg(`A_STATS + 8'(4 * `ST_CCPASS)); cmp(v, 32'h1);
    rreg(`A_STATS + 8'(4 * `ST_CCDROP)); cmp(v, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
